/* File: hdl/rtc_pkg.sv */
package rtc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] IDX_CTRL  = 8'h00;
  localparam logic [7:0] IDX_SYNC  = 8'h01;
  localparam logic [7:0] IDX_IRQL  = 8'h02;
  localparam logic [7:0] IDX_FLAGS = 8'h03;
  localparam logic [7:0] IDX_TRIM  = 8'h06;
  localparam logic [7:0] IDX_COUNT = 8'h08;
  localparam logic [7:0] IDX_WRAP  = 8'h0a;
  localparam logic [7:0] IDX_MATCH = 8'h0c;
  localparam int unsigned CTRL_CORR_BIT  = 3;
  localparam int unsigned CTRL_PSC_LSB   = 0;
  localparam int unsigned IRQL_MATCH_LSB = 2;
  localparam int unsigned IRQL_WRAP_LSB  = 0;
  localparam int unsigned FLAG_MATCH_BIT = 1;
  localparam int unsigned FLAG_WRAP_BIT  = 0;
  localparam int unsigned TRIM_SIGN_BIT  = 7;
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [1:0]  SYNC_EDGES   = 2'h2;
  localparam int unsigned DIV_W        = 10;
  localparam int unsigned CORR_INT_W   = 20;
  localparam int unsigned CORR_SLOT_LSB = 13;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PSC_OFF = 3'b000, PSC_DIV1 = 3'b001, PSC_HALVE_SETTING = 3'b010, PSC_DIV8 = 3'b011,
    PSC_DIV16 = 3'b100, PSC_DIV64 = 3'b101, PSC_DIV256 = 3'b110, PSC_DIV1024 = 3'b111
  } rtc_psc_t;

  typedef struct packed {
    logic match;
    logic wrap;
  } rtc_evt_t;

  typedef struct packed {
    logic       req;
    logic [1:0] level;
  } rtc_irq_t;

  typedef struct packed {
    logic       add;
    logic       skip;
  } rtc_corr_t;

  function automatic logic [ADDR_W-1:0] regAddr(input logic [7:0] idx);
    regAddr = {idx[5:0], 2'b00};
  endfunction
endpackage

/* File: hdl/rtc_prescaler.sv */
`timescale 1ns/1ns
module rtc_prescaler
  import rtc_pkg::*;
(
  input  wire logic      core_clk,
  input  wire logic      sys_rst,
  input  wire logic      rtcEdge,
  input  wire rtc_psc_t  pscSel,
  input  wire rtc_corr_t corr,
  output logic           tick
);
  logic [DIV_W-1:0] divCnt_reg;
  logic [DIV_W-1:0] divCnt_next;
  logic [DIV_W:0]   sum;
  logic [DIV_W-1:0] limit;
  logic [1:0]       step;
  logic             wrapNow;

  function automatic logic [DIV_W-1:0] divLimit(input rtc_psc_t sel);
    unique case (sel)
      PSC_OFF:     divLimit = 10'h000;
      PSC_DIV1:    divLimit = 10'h000;
      PSC_HALVE_SETTING:    divLimit = 10'h001;
      PSC_DIV8:    divLimit = 10'h007;
      PSC_DIV16:   divLimit = 10'h00f;
      PSC_DIV64:   divLimit = 10'h03f;
      PSC_DIV256:  divLimit = 10'h0ff;
      PSC_DIV1024: divLimit = 10'h3ff;
    endcase
  endfunction

  assign limit   = divLimit(pscSel);
  // Trim stalls one edge or advances by two
  assign step    = corr.add ? 2'h0 : (corr.skip ? 2'h2 : 2'h1);
  assign sum     = {1'b0, divCnt_reg} + {{(DIV_W-1){1'b0}}, step};
  assign wrapNow = rtcEdge && (pscSel != PSC_OFF) && (sum > {1'b0, limit});
  assign divCnt_next = wrapNow ? DIV_W'(sum - {1'b0, limit} - 11'h001) :
                       (rtcEdge && pscSel != PSC_OFF) ? sum[DIV_W-1:0] : divCnt_reg;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      divCnt_reg <= '0;
      tick       <= 1'b0;
    end else begin
      divCnt_reg <= divCnt_next;
      tick       <= wrapNow;
    end
  end
endmodule

/* File: hdl/rtc_top.sv */
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ns
module rtc_top
  import rtc_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              rtcClk,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              matchAck,
  input  wire logic              wrapAck,
  output rtc_irq_t               matchIrq,
  output rtc_irq_t               wrapIrq,
  output rtc_evt_t               evt
);
  // Bus side registers
  logic              awHeld_reg;
  logic              wHeld_reg;
  logic [ADDR_W-1:0] awAddr_reg;
  logic [31:0]       wData_reg;
  logic [3:0]        wStrb_reg;
  logic              wrEn;
  logic              mapW;
  logic              mapR;
  logic [31:0]       rdMux;
  logic              arTake;
  logic              lane0;
  logic              lane1;
  logic [15:0]       wrWord;

  // Software visible state
  logic [7:0]  ctrlShadow_reg;
  logic [7:0]  ctrlActive_reg;
  logic [7:0]  irqLevel_reg;
  logic [1:0]  flags_reg;
  logic [1:0]  flags_next;
  logic [7:0]  trim_reg;
  logic [15:0] cntShadow_reg;
  logic [15:0] wrapShadow_reg;
  logic [15:0] matchShadow_reg;
  logic [15:0] cntReg_reg;
  logic [15:0] wrap_reg;
  logic [15:0] match_reg;
  logic [3:0]  pendMask_reg;
  logic [1:0]  pendCnt_reg;
  logic        pendFlag;
  logic        applyNow;

  // Counter side
  logic        rtcPrev_reg;
  logic        rtcEdge;
  logic        tick;
  rtc_corr_t   corr;
  logic        wrapHit;
  logic        matchHit;
  logic [1:0]  wrapDiv_reg;
  logic [1:0]  matchDiv_reg;
  logic [1:0]  evtMod;
  logic        wrCtrl;
  logic        wrIrql;
  logic        wrFlags;
  logic        wrTrim;
  logic        wrCount;
  logic        wrWrap;
  logic        wrMatch;

  function automatic logic [1:0] eventModulo(input logic [15:0] limit);
    eventModulo = (limit == 16'h0000) ? 2'h3 : ((limit == 16'h0001) ? 2'h2 : 2'h1);
  endfunction

  function automatic logic [1:0] divStep(input logic [1:0] cur, input logic [1:0] modulo);
    divStep = (cur + 2'h1 >= modulo) ? 2'h0 : cur + 2'h1;
  endfunction

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    isMapped = (a == regAddr(IDX_CTRL)) || (a == regAddr(IDX_SYNC)) || (a == regAddr(IDX_IRQL)) ||
               (a == regAddr(IDX_FLAGS)) || (a == regAddr(IDX_TRIM)) || (a == regAddr(IDX_COUNT)) ||
               (a == regAddr(IDX_WRAP)) || (a == regAddr(IDX_MATCH));
  endfunction

  // AXI4-Lite write: address and data taken in either order, answer after both
  assign awready = !awHeld_reg;
  assign wready  = !wHeld_reg;
  assign wrEn    = awHeld_reg && wHeld_reg && !bvalid;
  assign mapW    = isMapped(awAddr_reg);
  assign lane0   = wStrb_reg[0];
  assign lane1   = wStrb_reg[1];
  assign wrWord  = {lane1 ? wData_reg[15:8] : 8'h00, lane0 ? wData_reg[7:0] : 8'h00};
  assign wrCtrl  = wrEn && lane0 && awAddr_reg == regAddr(IDX_CTRL);
  assign wrIrql  = wrEn && lane0 && awAddr_reg == regAddr(IDX_IRQL);
  assign wrFlags = wrEn && lane0 && awAddr_reg == regAddr(IDX_FLAGS);
  assign wrTrim  = wrEn && lane0 && awAddr_reg == regAddr(IDX_TRIM);
  assign wrCount = wrEn && (lane0 || lane1) && awAddr_reg == regAddr(IDX_COUNT);
  assign wrWrap  = wrEn && (lane0 || lane1) && awAddr_reg == regAddr(IDX_WRAP);
  assign wrMatch = wrEn && (lane0 || lane1) && awAddr_reg == regAddr(IDX_MATCH);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      awHeld_reg <= 1'b0;
      wHeld_reg  <= 1'b0;
      awAddr_reg <= '0;
      wData_reg  <= '0;
      wStrb_reg  <= '0;
      bvalid     <= 1'b0;
      bresp      <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
      end
      if (wrEn) begin
        bvalid     <= 1'b1;
        bresp      <= mapW ? RESP_OKAY : RESP_SLVERR;
        awHeld_reg <= 1'b0;
        wHeld_reg  <= 1'b0;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read: one cycle from address to data
  assign arready = !rvalid;
  assign arTake  = arvalid && arready;
  assign mapR    = isMapped(araddr);
  assign rdMux   = (araddr == regAddr(IDX_CTRL))  ? {24'h000000, 4'h0, ctrlShadow_reg[3:0]} :
                   (araddr == regAddr(IDX_SYNC))  ? {31'h00000000, pendFlag} :
                   (araddr == regAddr(IDX_IRQL))  ? {24'h000000, 4'h0, irqLevel_reg[3:0]} :
                   (araddr == regAddr(IDX_FLAGS)) ? {30'h00000000, flags_reg} :
                   (araddr == regAddr(IDX_TRIM))  ? {24'h000000, trim_reg} :
                   (araddr == regAddr(IDX_COUNT)) ? {16'h0000, cntReg_reg} :
                   (araddr == regAddr(IDX_WRAP))  ? {16'h0000, wrapShadow_reg} :
                   (araddr == regAddr(IDX_MATCH)) ? {16'h0000, matchShadow_reg} : 32'h00000000;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else if (arTake) begin
      rvalid <= 1'b1;
      rdata  <= rdMux;
      rresp  <= mapR ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // Directly applied registers: level, trim
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqLevel_reg <= RST_BYTE;
      trim_reg     <= RST_BYTE;
    end else begin
      if (wrIrql) begin
        irqLevel_reg <= {4'h0, wData_reg[3:0]};
      end
      if (wrTrim) begin
        trim_reg <= wData_reg[7:0];
      end
    end
  end

  // Counter clock taken as a synchronous input; rising edges drive the count
  assign rtcEdge  = rtcClk && !rtcPrev_reg;
  assign pendFlag = (pendCnt_reg != 2'h0);
  assign applyNow = rtcEdge && (pendCnt_reg == 2'h1);

  // Crossing: writes land in shadows and reach the counter two counter edges later
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rtcPrev_reg     <= 1'b0;
      pendCnt_reg     <= 2'h0;
      pendMask_reg    <= 4'h0;
      ctrlShadow_reg  <= RST_BYTE;
      cntShadow_reg   <= RST_WORD;
      wrapShadow_reg  <= RST_WORD;
      matchShadow_reg <= RST_WORD;
    end else begin
      rtcPrev_reg <= rtcClk;
      if (wrCtrl || wrCount || wrWrap || wrMatch) begin
        pendCnt_reg  <= SYNC_EDGES;
        pendMask_reg <= pendMask_reg | {wrMatch, wrWrap, wrCount, wrCtrl};
      end else if (rtcEdge && pendFlag) begin
        pendCnt_reg <= pendCnt_reg - 2'h1;
        if (applyNow) begin
          pendMask_reg <= 4'h0;
        end
      end
      if (wrCtrl) begin
        ctrlShadow_reg <= {4'h0, wData_reg[3:0]};
      end
      if (wrCount) begin
        cntShadow_reg <= wrWord;
      end
      if (wrWrap) begin
        wrapShadow_reg <= wrWord;
      end
      if (wrMatch) begin
        matchShadow_reg <= wrWord;
      end
    end
  end

  rtc_trim uTrim (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .rtcEdge    (rtcEdge),
    .corrEnable (ctrlActive_reg[CTRL_CORR_BIT]),
    .trimValue  (trim_reg),
    .corr       (corr)
  );

  rtc_prescaler uPsc (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .rtcEdge  (rtcEdge),
    .pscSel   (rtc_psc_t'(ctrlActive_reg[CTRL_PSC_LSB +: 3])),
    .corr     (corr),
    .tick     (tick)
  );

  // Hits are judged on the value present at the prescaled count
  assign wrapHit  = tick && (cntReg_reg == wrap_reg);
  assign matchHit = tick && (cntReg_reg == match_reg) && (match_reg <= wrap_reg);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrlActive_reg <= RST_BYTE;
      cntReg_reg     <= RST_WORD;
      wrap_reg       <= RST_WORD;
      match_reg      <= RST_WORD;
    end else begin
      if (applyNow && pendMask_reg[0]) begin
        ctrlActive_reg <= ctrlShadow_reg;
      end
      if (applyNow && pendMask_reg[2]) begin
        wrap_reg <= wrapShadow_reg;
      end
      if (applyNow && pendMask_reg[3]) begin
        match_reg <= matchShadow_reg;
      end
      if (applyNow && pendMask_reg[1]) begin
        cntReg_reg <= cntShadow_reg;
      end else if (wrapHit) begin
        cntReg_reg <= RST_WORD;
      end else if (tick) begin
        cntReg_reg <= cntReg_reg + 16'h0001;
      end
    end
  end

  // Flags: a hit in the same cycle as a clear keeps the flag set
  always_comb begin
    flags_next = flags_reg;
    if (wrFlags && wData_reg[FLAG_MATCH_BIT]) begin
      flags_next[FLAG_MATCH_BIT] = 1'b0;
    end
    if (wrFlags && wData_reg[FLAG_WRAP_BIT]) begin
      flags_next[FLAG_WRAP_BIT] = 1'b0;
    end
    if (matchAck) begin
      flags_next[FLAG_MATCH_BIT] = 1'b0;
    end
    if (wrapAck) begin
      flags_next[FLAG_WRAP_BIT] = 1'b0;
    end
    if (matchHit) begin
      flags_next[FLAG_MATCH_BIT] = 1'b1;
    end
    if (wrapHit) begin
      flags_next[FLAG_WRAP_BIT] = 1'b1;
    end
  end

  // Event thinning for very short wrap limits
  assign evtMod = eventModulo(wrap_reg);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_reg    <= 2'h0;
      wrapDiv_reg  <= 2'h0;
      matchDiv_reg <= 2'h0;
      evt          <= '0;
    end else begin
      flags_reg <= flags_next;
      // A divider left over from a shorter wrap limit does not thin events once the wrap limit is two or more
      evt.wrap  <= wrapHit && ((wrapDiv_reg == 2'h0) || (evtMod == 2'h1));
      evt.match <= matchHit && ((matchDiv_reg == 2'h0) || (evtMod == 2'h1));
      if (wrapHit) begin
        wrapDiv_reg <= divStep(wrapDiv_reg, evtMod);
      end
      if (matchHit) begin
        matchDiv_reg <= divStep(matchDiv_reg, evtMod);
      end
    end
  end

  assign matchIrq.level = irqLevel_reg[IRQL_MATCH_LSB +: 2];
  assign matchIrq.req   = flags_reg[FLAG_MATCH_BIT] && (matchIrq.level != 2'h0);
  assign wrapIrq.level  = irqLevel_reg[IRQL_WRAP_LSB +: 2];
  assign wrapIrq.req    = flags_reg[FLAG_WRAP_BIT] && (wrapIrq.level != 2'h0);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence wrapSeen;
    wrapHit && !(applyNow && pendMask_reg[1]);
  endsequence

  sequence countWrite;
    wrCount ##1 pendFlag;
  endsequence

  busyClear_a: assert property (applyNow |=> !pendFlag)
    else $error("pending flag stayed set after update applied");
  wrapZero_a: assert property (wrapSeen |=> cntReg_reg == 16'h0000)
    else $error("count did not return to zero on overflow");
  wrapFlag_a: assert property (wrapHit |=> flags_reg[FLAG_WRAP_BIT])
    else $error("wrap flag not set after overflow");
  matchFlag_a: assert property (matchHit |=> flags_reg[FLAG_MATCH_BIT])
    else $error("match flag not set after compare match");
  noMatch_a: assert property (tick && match_reg > wrap_reg |=> !evt.match)
    else $error("compare event with match above wrap limit");
  wrapEvent_a: assert property (wrapHit && wrap_reg >= 16'h0002 |=> evt.wrap)
    else $error("overflow event missing for wrap limit of two or more");
  matchIrq_a: assert property (flags_reg[FLAG_MATCH_BIT] && irqLevel_reg[3:2] != 2'h0 |-> matchIrq.req)
    else $error("match request missing while flag set and enabled");
  wrapIrq_a: assert property ($rose(flags_reg[FLAG_WRAP_BIT]) && wrapIrq.level != 2'h0 |-> wrapIrq.req)
    else $error("wrap request missing after flag set");
  writeBusy_a: assert property (countWrite |-> pendFlag throughout (##[0:1] pendFlag))
    else $error("count write did not show pending");
  eventPulse_a: assert property (evt.wrap |=> !evt.wrap)
    else $error("overflow event longer than one cycle");
  stopHold_a: assert property (ctrlActive_reg[2:0] == 3'h0 && $past(ctrlActive_reg[2:0]) == 3'h0 && !applyNow
                               |=> $stable(cntReg_reg))
    else $error("count moved while prescaler off");
endmodule

/* File: hdl/rtc_trim.sv */
`timescale 1ns/1ns
module rtc_trim
  import rtc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       rtcEdge,
  input  wire logic       corrEnable,
  input  wire logic [7:0] trimValue,
  output rtc_corr_t       corr
);
  logic [CORR_INT_W-1:0] intCnt_reg;
  logic                  active_reg;
  logic                  slotStart;
  logic                  doCorr;
  logic                  intEnd;

  // Slots of 8192 edges; one correction at the start of each slot below magnitude
  assign slotStart = (intCnt_reg[CORR_SLOT_LSB-1:0] == '0);
  assign doCorr    = active_reg && rtcEdge && slotStart &&
                     (intCnt_reg[CORR_INT_W-1:CORR_SLOT_LSB] < trimValue[6:0]);
  assign corr.add  = doCorr && !trimValue[TRIM_SIGN_BIT];
  assign corr.skip = doCorr && trimValue[TRIM_SIGN_BIT];
  assign intEnd    = (intCnt_reg == '1);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      intCnt_reg <= '0;
      active_reg <= 1'b0;
    end else if (!active_reg) begin
      active_reg <= corrEnable;
      intCnt_reg <= '0;
    end else if (rtcEdge) begin
      intCnt_reg <= intCnt_reg + 1'b1;
      if (intEnd) begin
        active_reg <= corrEnable;
      end
    end
  end
endmodule

/* File: tb/realtime_counter_with_trim_tb.sv */
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; $display("ERROR %0t got %h exp %h", $time, a, b); end end
module realtime_counter_with_trim_tb
  import rtc_pkg::*;
;
  logic        core_clk, sys_rst, rtcClk, awvalid, wvalid, bready, arvalid, rready, ackEn;
  logic        awready, wready, bvalid, arready, rvalid, matchAck, wrapAck, prevW;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, q, rndState;
  logic [3:0]  wstrb;
  logic [2:0]  ackDelay;
  logic [1:0]  bresp, rresp, lastResp;
  rtc_irq_t    matchIrq, wrapIrq;
  rtc_evt_t    evt;
  int          n_errors, n_tests, cyc, nWrap, nMatch, lastWrap, lastMatch, wrapGap, w, m;
  int          divTab[8] = '{0, 1, 2, 8, 16, 64, 256, 1024};
  logic [7:0]  regIdx[8] = '{IDX_CTRL, IDX_SYNC, IDX_IRQL, IDX_FLAGS, IDX_TRIM, IDX_COUNT, IDX_WRAP, IDX_MATCH};

  rtc_top i_rtc_top (.core_clk(core_clk), .sys_rst(sys_rst), .rtcClk(rtcClk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .matchAck(matchAck), .wrapAck(wrapAck),
    .matchIrq(matchIrq), .wrapIrq(wrapIrq), .evt(evt));
  rtc_irq_host i_rtc_irq_host (.core_clk(core_clk), .sys_rst(sys_rst), .matchIrq(matchIrq), .wrapIrq(wrapIrq),
    .ackEn(ackEn), .delay(ackDelay), .matchAck(matchAck), .wrapAck(wrapAck));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Counter clock of four core cycles, offset in phase
  initial begin
    rtcClk = 1'b0;
    #130;
    forever #200 rtcClk = ~rtcClk;
  end

  function automatic logic [31:0] rnd();
    rndState ^= rndState << 13;
    rndState ^= rndState >> 17;
    rndState ^= rndState << 5;
    return rndState;
  endfunction
  // Core cycles between wrap events: hits per event times ticks per hit times divider times four core cycles per counter edge
  function automatic int gapOf(input int wl, input int c);
    return (wl == 0 ? 3 : wl == 1 ? 2 : 1) * (wl + 1) * divTab[c] * 4;
  endfunction

  always @(negedge core_clk) begin
    cyc++;
    if (evt.match === 1'b1) begin
      nMatch++;
      lastMatch = cyc;
    end
    if (evt.wrap === 1'b1) begin
      `CHK(prevW, 1'b0)
      nWrap++;
      wrapGap = cyc - lastWrap;
      lastWrap = cyc;
    end
    prevW = evt.wrap;
  end

  // Handshake signals are checked at the negedge, where they equal their values at the next rising edge
  task automatic bus(input logic wrn, input logic [7:0] ix, input logic [31:0] d, output logic [31:0] rd);
    int t;
    logic ta, tw, done;
    t = 0;
    done = 1'b0;
    if (wrn) begin
      awaddr <= {ix[5:0], 2'b00};
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= {ix[5:0], 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    while (!done && t < 50) begin
      @(negedge core_clk);
      t++;
      ta = wrn ? (awvalid && awready) : (arvalid && arready);
      tw = wvalid && wready;
      done = wrn ? (bvalid === 1'b1) : (rvalid === 1'b1);
      rd = rdata;
      lastResp = wrn ? bresp : rresp;
      @(posedge core_clk);
      if (ta) begin
        awvalid <= 1'b0;
        arvalid <= 1'b0;
      end
      if (tw) wvalid <= 1'b0;
      if (done) begin
        bready <= 1'b0;
        rready <= 1'b0;
      end
    end
    // One idle edge so a following call never re-raises a ready in the same step
    @(posedge core_clk);
    `CHK(done, 1'b1)
  endtask
  task automatic wr(input logic [7:0] ix, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, ix, d, dummy);
  endtask
  task automatic rd(input logic [7:0] ix, output logic [31:0] d);
    bus(1'b0, ix, 32'h0, d);
  endtask
  task automatic waitIdle();
    int t;
    t = 0;
    q = 32'h1;
    while (q[0] !== 1'b0 && t < 20) begin
      rd(IDX_SYNC, q);
      t++;
    end
    `CHK(q[0], 1'b0)
  endtask
  task automatic setReg(input logic [7:0] ix, input logic [31:0] d);
    wr(ix, d);
    waitIdle();
  endtask
  task automatic waitWrap(input int n);
    int t;
    t = 0;
    while (nWrap < n && t < 40000) begin
      @(posedge core_clk);
      t++;
    end
    `CHK(nWrap >= n, 1'b1)
  endtask
  task automatic settle();
    @(negedge core_clk);
  endtask

  initial begin
    {sys_rst, awvalid, wvalid, bready, arvalid, rready, ackEn, prevW} = 8'h80;
    {awaddr, araddr, wdata, wstrb, ackDelay} = '0;
    rndState = 32'h034cb424;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    foreach (regIdx[i]) begin
      rd(regIdx[i], q);
      `CHK(q, 32'h0)
    end
    rd(8'h05, q);
    `CHK({lastResp, q}, {RESP_SLVERR, 32'h0})
    wr(8'h05, rnd());
    `CHK(lastResp, RESP_SLVERR)
    repeat (4) begin
      w = rnd();
      wr(IDX_IRQL, w & 32'hf);
      rd(IDX_IRQL, q);
      `CHK(q, w & 32'hf)
      wr(IDX_TRIM, w & 32'hff);
      rd(IDX_TRIM, q);
      `CHK(q, w & 32'hff)
    end
    $display("test registers done");
    wr(IDX_WRAP, 32'h2);
    rd(IDX_SYNC, q);
    `CHK(q[0], 1'b1)
    waitIdle();
    m = rnd() % 3;
    setReg(IDX_COUNT, m);
    rd(IDX_COUNT, q);
    `CHK(q, m)
    setReg(IDX_MATCH, m);
    for (int c = 1; c < 8; c++) begin
      setReg(IDX_CTRL, c);
      waitWrap(nWrap + 3);
      `CHK(wrapGap, gapOf(2, c))
      `CHK(lastWrap - lastMatch, (2 - m) * divTab[c] * 4)
    end
    $display("test prescaler done");
    setReg(IDX_CTRL, 32'h1);
    wr(IDX_IRQL, 32'h6);
    waitWrap(nWrap + 1);
    setReg(IDX_CTRL, 32'h0);
    rd(IDX_FLAGS, q);
    `CHK(q, 32'h3)
    settle();
    `CHK(wrapIrq, 3'b110)
    `CHK(matchIrq, 3'b101)
    @(posedge core_clk);
    wr(IDX_FLAGS, 32'h1);
    rd(IDX_FLAGS, q);
    `CHK(q, 32'h2)
    ackEn <= 1'b1;
    ackDelay <= rnd() % 8;
    repeat (12) @(posedge core_clk);
    settle();
    `CHK({matchIrq.req, wrapIrq.req}, 2'b00)
    @(posedge core_clk);
    ackEn <= 1'b0;
    w = nWrap;
    repeat (200) @(posedge core_clk);
    `CHK(nWrap, w)
    $display("test flags done");
    for (int k = 0; k < 4; k++) begin
      setReg(IDX_CTRL, 32'h0);
      setReg(IDX_COUNT, 32'h0);
      setReg(IDX_WRAP, k % 3);
      setReg(IDX_MATCH, k == 3 ? 3 : 0);
      setReg(IDX_CTRL, 32'h1);
      m = nMatch;
      waitWrap(nWrap + 3);
      `CHK(wrapGap, gapOf(k % 3, 1))
      if (k == 3) `CHK(nMatch, m)
    end
    $display("test thinning done");
    test_done();
  end

  initial begin
    #9500000;
    n_errors++;
    test_done();
  end

  task automatic test_done();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
endmodule

/* File: tb/rtc_irq_host.sv */
`timescale 1ns/1ns
module rtc_irq_host
  import rtc_pkg::*;
(
  input  wire logic     core_clk,
  input  wire logic     sys_rst,
  input  wire rtc_irq_t matchIrq,
  input  wire rtc_irq_t wrapIrq,
  input  wire logic     ackEn,
  input  wire logic [2:0] delay,
  output logic          matchAck,
  output logic          wrapAck
);
  // Serves the higher level first, after a programmable vector latency
  logic [2:0] waitCnt;
  wire        pend       = ackEn && (matchIrq.req || wrapIrq.req) && !matchAck && !wrapAck;
  wire        matchFirst = matchIrq.req && (!wrapIrq.req || matchIrq.level >= wrapIrq.level);
  wire        fire       = pend && waitCnt == delay;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      waitCnt  <= 3'h0;
      matchAck <= 1'b0;
      wrapAck  <= 1'b0;
    end else begin
      waitCnt  <= pend ? waitCnt + 3'h1 : 3'h0;
      matchAck <= fire && matchFirst;
      wrapAck  <= fire && !matchFirst;
    end
  end
endmodule
